// *** rtl/gpio_port_pkg.sv ***
/*
  Package for the six-pin port: register offsets, field positions and reset values.
  Assumes a 32-bit APB master with word-aligned register accesses.
*/
package gpio_port_pkg;

  // ==========================================================================
  // Register byte offsets.
  localparam logic [7:0] OFS_PORT_DATA   = 8'h00;
  localparam logic [7:0] OFS_DIRECTION   = 8'h04;
  localparam logic [7:0] OFS_PULLUP      = 8'h08;
  localparam logic [7:0] OFS_PULLDOWN    = 8'h0C;
  localparam logic [7:0] OFS_OPEN_DRAIN  = 8'h10;
  localparam logic [7:0] OFS_WAKEUP      = 8'h14;
  localparam logic [7:0] OFS_INT_FLAGS   = 8'h18;
  localparam logic [7:0] OFS_INT_ENABLES = 8'h1C;
  localparam logic [7:0] OFS_PWR_CTRL    = 8'h20;
  localparam logic [7:0] OFS_PWR_CTRL_1  = 8'h24;
  localparam logic [7:0] OFS_CARRIER     = 8'h28;
  localparam logic [7:0] OFS_READ_SRC    = 8'h2C;

  // ==========================================================================
  // Field positions.
  localparam int PIN_COUNT        = 6;
  localparam int BIT_PORT_CHANGE  = 1;
  localparam int BIT_EXT_INT      = 2;
  localparam int BIT_GIE          = 7;
  localparam int BIT_EXT_SELECT   = 6;
  localparam int BIT_EXT_EDGE     = 5;
  localparam int BIT_CARRIER_EN   = 0;
  localparam int PULLDOWN_LSB     = 4;

  // ==========================================================================
  // Reset values.
  localparam logic [5:0] RST_DIRECTION = 6'h3F;
  localparam logic [5:0] RST_ZERO6     = 6'h00;

endpackage

// *** rtl/gpio_port.sv ***
/*
  Six-pin bidirectional port with per-pin direction, pulls, open-drain, read source,
  level-change flag, external interrupt on pin 0 and alternate functions.
  Assumes an APB master on sys_clk and pad cells that resolve enables to a wire.
*/
// Our own choices: the register offsets and the APB slave port.
// Functional notes
// - Six pins 0..5 read and written through one port data register.
// - Direction register bits 5..0 make each pin input (1) or output (0).
// - Pull-up register bits 5..0 enable pull-high on input pins.
// - Pull-down bits 7..4 enable pull-low for pins 3..0; pins 5,4 have none.
// - Open-drain bits 5..0 choose push-pull or open-drain per output pin.
// - Pin 3 is always open-drain when output.
// - Wake-up enable bits 5..0 select pins for level-change detection.
// - Level change on a selected pin sets port-change flag, flags bit 1.
// - External-interrupt select bit 6 makes pin 0 the external interrupt input.
// - External interrupt on pin 0 disables pin 0 level-change; others unaffected.
// - Edge select picks which pin 0 transition triggers the external interrupt.
// - Carrier enable bit 0 drives the IR carrier onto pin 1.
// - Configured pin 3 acts as active-low external reset input.
// - In normal or standby mode, with config, instruction clock drives pin 4.
// - Pin 2 feeds external clock to timer0 and timer1 per source bits.
// - Pin 2 carries PWM or buzzer output when enabled and configured.
// - Per-pin read source returns pin level or output latch.
// - PWM output enable forces pin 2 to output.
// - Carrier enable forces pin 1 to output; clearing restores normal use.
`timescale 1ns/100ps

module gpio_port
  import gpio_port_pkg::*;
(
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Pads.
  input  wire logic [5:0]  port_pins_in,
  output logic      [5:0]  port_pins_out,
  output logic      [5:0]  port_pins_oe,
  output logic      [5:0]  pad_pullhigh_en_n,
  output logic      [3:0]  pad_pulldown_en,
  // Configuration words and mode.
  input  wire logic        reset_pad_enable,
  input  wire logic        clk_out_cfg,
  input  wire logic        pwm_cfg,
  input  wire logic        buzzer_cfg,
  input  wire logic [1:0]  op_mode,
  // Alternate functions.
  input  wire logic        carrier_out_data,
  input  wire logic        instr_clk_level,
  input  wire logic        pwm_out_enable,
  input  wire logic        buzzer_enable,
  input  wire logic        pwm_level,
  input  wire logic        buzzer_level,
  input  wire logic        t0_clock_source,
  input  wire logic        t0_low_clock_sel,
  input  wire logic        t1_clock_source,
  output logic             t0_ext_clock_in,
  output logic             t1_ext_clock_in,
  output logic             reset_pad_input_n,
  // Interrupts.
  output logic             port_change_irq,
  output logic             ext_int_irq
);

  // ==========================================================================
  // Registers.
  logic [5:0] port_data_reg_r;
  logic [5:0] pin_direction_r;
  logic [5:0] pullup_control_r;
  logic [3:0] pulldown_control_r;
  logic [5:0] open_drain_control_r;
  logic [5:0] wakeup_enable_r;
  logic [5:0] read_source_r;
  logic       port_change_flag_r;
  logic       ext_int_flag_r;
  logic [1:0] interrupt_enables_r;
  logic       ext_int_select_r;
  logic       ext_int_edge_sel_r;
  logic       global_int_enable_r;
  logic       carrier_enable_r;
  logic [5:0] sample_r;
  logic [5:0] prev_r;
  logic [5:0] change_nxt;
  logic [5:0] wake_eff;
  logic       ext_edge;
  logic       wr_en;
  logic       rd_hit;
  logic [5:0] pin_read;
  logic       pwm_on;
  logic       buz_on;
  logic       clk_on;

  assign wr_en   = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign pwm_on  = pwm_out_enable && pwm_cfg;
  assign buz_on  = buzzer_enable && buzzer_cfg;
  assign clk_on  = clk_out_cfg && (op_mode == 2'b00 || op_mode == 2'b10);

  // ==========================================================================
  // Software-written configuration.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      port_data_reg_r      <= RST_ZERO6;
      pin_direction_r      <= RST_DIRECTION;
      pullup_control_r     <= RST_ZERO6;
      pulldown_control_r   <= 4'h0;
      open_drain_control_r <= RST_ZERO6;
      wakeup_enable_r      <= RST_ZERO6;
      read_source_r        <= RST_ZERO6;
      interrupt_enables_r  <= 2'h0;
      ext_int_select_r     <= 1'b0;
      ext_int_edge_sel_r   <= 1'b0;
      global_int_enable_r  <= 1'b0;
      carrier_enable_r     <= 1'b0;
    end
    else if (wr_en)
    begin
      case (paddr)
        OFS_PORT_DATA:   port_data_reg_r      <= pwdata[5:0];
        OFS_DIRECTION:   pin_direction_r      <= pwdata[5:0];
        OFS_PULLUP:      pullup_control_r     <= pwdata[5:0];
        OFS_PULLDOWN:    pulldown_control_r   <= pwdata[7:4];
        OFS_OPEN_DRAIN:  open_drain_control_r <= pwdata[5:0];
        OFS_WAKEUP:      wakeup_enable_r      <= pwdata[5:0];
        OFS_READ_SRC:    read_source_r        <= pwdata[5:0];
        OFS_INT_ENABLES: interrupt_enables_r  <= pwdata[2:1];
        OFS_PWR_CTRL:
        begin
          ext_int_select_r   <= pwdata[BIT_EXT_SELECT];
          ext_int_edge_sel_r <= pwdata[BIT_EXT_EDGE];
        end
        OFS_PWR_CTRL_1:  global_int_enable_r  <= pwdata[BIT_GIE];
        OFS_CARRIER:     carrier_enable_r     <= pwdata[BIT_CARRIER_EN];
        default:         ;
      endcase
    end
  end

  // ==========================================================================
  // Pin sampling and change detection.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      sample_r <= RST_ZERO6;
      prev_r   <= RST_ZERO6;
    end
    else
    begin
      sample_r <= port_pins_in;
      prev_r   <= sample_r;
    end
  end

  assign wake_eff = {wakeup_enable_r[5:1], wakeup_enable_r[0] & ~ext_int_select_r};

  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g++)
    begin : g_chg
      assign change_nxt[g] = wake_eff[g] && (sample_r[g] != prev_r[g]);
    end
  endgenerate

  assign ext_edge = ext_int_select_r &&
                    (ext_int_edge_sel_r ? (prev_r[0] && !sample_r[0])
                                        : (!prev_r[0] && sample_r[0]));

  // ==========================================================================
  // Interrupt flags: hardware set wins over a software clear.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      port_change_flag_r <= 1'b0;
      ext_int_flag_r     <= 1'b0;
    end
    else
    begin
      if (|change_nxt)
        port_change_flag_r <= 1'b1;
      else if (wr_en && paddr == OFS_INT_FLAGS && !pwdata[BIT_PORT_CHANGE])
        port_change_flag_r <= 1'b0;
      if (ext_edge)
        ext_int_flag_r <= 1'b1;
      else if (wr_en && paddr == OFS_INT_FLAGS && !pwdata[BIT_EXT_INT])
        ext_int_flag_r <= 1'b0;
    end
  end

  assign port_change_irq = port_change_flag_r && interrupt_enables_r[0] &&
                           global_int_enable_r;
  assign ext_int_irq     = ext_int_flag_r && interrupt_enables_r[1] && global_int_enable_r;

  // ==========================================================================
  // Pad drive.
  logic [5:0] out_val;
  logic [5:0] is_out;
  logic [5:0] od;

  always_comb
  begin
    out_val = port_data_reg_r;
    is_out  = ~pin_direction_r;
    od      = open_drain_control_r;
    od[3]   = 1'b1;
    if (carrier_enable_r)
    begin
      is_out[1]  = 1'b1;
      out_val[1] = carrier_out_data;
    end
    if (pwm_on)
    begin
      is_out[2]  = 1'b1;
      out_val[2] = pwm_level;
    end
    else if (buz_on)
    begin
      is_out[2]  = 1'b1;
      out_val[2] = buzzer_level;
    end
    if (clk_on)
    begin
      is_out[4]  = 1'b1;
      out_val[4] = instr_clk_level;
    end
    if (reset_pad_enable)
      is_out[3] = 1'b0;
  end

  assign port_pins_out     = out_val & ~od;
  assign port_pins_oe      = is_out & (~od | ~out_val);
  assign pad_pullhigh_en_n = ~(pullup_control_r & ~is_out);
  assign pad_pulldown_en   = pulldown_control_r & ~is_out[3:0];

  assign reset_pad_input_n = reset_pad_enable ? sample_r[3] : 1'b1;
  assign t0_ext_clock_in   = t0_clock_source && !t0_low_clock_sel && sample_r[2];
  assign t1_ext_clock_in   = t1_clock_source && sample_r[2];

  // ==========================================================================
  // Read path.
  generate
    for (g = 0; g < PIN_COUNT; g++)
    begin : g_rd
      assign pin_read[g] = read_source_r[g] ? port_data_reg_r[g] : sample_r[g];
    end
  endgenerate

  always_comb
  begin
    rd_hit = 1'b1;
    prdata = 32'h0000_0000;
    case (paddr)
      OFS_PORT_DATA:   prdata[5:0] = pin_read;
      OFS_DIRECTION:   prdata[5:0] = pin_direction_r;
      OFS_PULLUP:      prdata[5:0] = pullup_control_r;
      OFS_PULLDOWN:    prdata[7:4] = pulldown_control_r;
      OFS_OPEN_DRAIN:  prdata[5:0] = open_drain_control_r;
      OFS_WAKEUP:      prdata[5:0] = wakeup_enable_r;
      OFS_READ_SRC:    prdata[5:0] = read_source_r;
      OFS_INT_FLAGS:   prdata[2:1] = {ext_int_flag_r, port_change_flag_r};
      OFS_INT_ENABLES: prdata[2:1] = interrupt_enables_r;
      OFS_PWR_CTRL:    prdata[6:5] = {ext_int_select_r, ext_int_edge_sel_r};
      OFS_PWR_CTRL_1:  prdata[7]   = global_int_enable_r;
      OFS_CARRIER:     prdata[0]   = carrier_enable_r;
      default:         rd_hit      = 1'b0;
    endcase
  end

  assign pslverr = psel && penable && !rd_hit;

  // ==========================================================================
  // Assertions.
  property p_change_sets;
    @(posedge sys_clk) disable iff (rst) |change_nxt |=> port_change_flag_r;
  endproperty
  a_change_sets: assert property (p_change_sets) else $error("change not flagged");

  property p_irq_gate;
    @(posedge sys_clk) disable iff (rst)
      port_change_irq |-> (interrupt_enables_r[0] && global_int_enable_r);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without enables");

  property p_pin0_masked;
    @(posedge sys_clk) disable iff (rst) ext_int_select_r |-> !change_nxt[0];
  endproperty
  a_pin0_masked: assert property (p_pin0_masked) else $error("pin0 change leaked");

  property p_pin3_od;
    @(posedge sys_clk) disable iff (rst)
      !port_pins_out[3] && !(port_data_reg_r[3] && port_pins_oe[3]);
  endproperty
  a_pin3_od: assert property (p_pin3_od) else $error("pin3 drove high");

  property p_push_pull;
    @(posedge sys_clk) disable iff (rst)
      (!pin_direction_r[5] && !open_drain_control_r[5]) |->
        (port_pins_oe[5] && port_pins_out[5] == port_data_reg_r[5]);
  endproperty
  a_push_pull: assert property (p_push_pull) else $error("pin5 push-pull wrong");

  property p_reset_pad;
    @(posedge sys_clk) disable iff (rst)
      reset_pad_enable |-> (!port_pins_oe[3] && reset_pad_input_n == sample_r[3]);
  endproperty
  a_reset_pad: assert property (p_reset_pad) else $error("reset pad not input");

  property p_pwm_force;
    @(posedge sys_clk) disable iff (rst)
      (pwm_on && !open_drain_control_r[2] && !reset_pad_enable) |-> port_pins_oe[2];
  endproperty
  a_pwm_force: assert property (p_pwm_force) else $error("pin2 not output");

  property p_carrier_force;
    @(posedge sys_clk) disable iff (rst)
      (carrier_enable_r && !open_drain_control_r[1]) |-> port_pins_oe[1];
  endproperty
  a_carrier_force: assert property (p_carrier_force) else $error("pin1 not output");

  property p_sample_chain;
    @(posedge sys_clk) disable iff (rst)
      !rst |-> ##2 (prev_r == $past(port_pins_in, 2));
  endproperty
  a_sample_chain: assert property (p_sample_chain) else $error("sample chain wrong");

  property p_ext_edge;
    @(posedge sys_clk) disable iff (rst) ext_edge |=> ext_int_flag_r;
  endproperty
  a_ext_edge: assert property (p_ext_edge) else $error("ext edge lost");

  c_change: cover property (@(posedge sys_clk) disable iff (rst) |change_nxt);
  c_ext:    cover property (@(posedge sys_clk) disable iff (rst) ext_edge);
  c_irq:    cover property (@(posedge sys_clk) disable iff (rst) port_change_irq);
  c_ext_irq: cover property (@(posedge sys_clk) disable iff (rst) ext_int_irq);

endmodule

// *** sim/pad_model.sv ***
/*
  Off-chip pad model for the six-pin port: resolves each pin from the port's
  drive, an external driver and the pulls. Assumes sys_clk from the bench.
*/
`timescale 1ns/100ps
module pad_model
(
  // Clock.
  input  wire logic       sys_clk,
  // Port side.
  input  wire logic [5:0] pin_out,
  input  wire logic [5:0] pin_oe,
  input  wire logic [5:0] pull_n,
  input  wire logic [3:0] pull_dn,
  // External driver.
  input  wire logic [5:0] ext_en,
  input  wire logic [5:0] ext_val,
  // Resolved levels.
  output logic      [5:0] pin_level
);
  logic [5:0] last_r = 6'h00;
  logic [5:0] pd6;
  assign pd6 = {2'b00, pull_dn};
  // A pin nobody drives or pulls shows the inverse of its last level.
  always_comb
  begin
    for (int i = 0; i < 6; i++)
    begin
      if (pin_oe[i])
        pin_level[i] = pin_out[i];
      else if (ext_en[i])
        pin_level[i] = ext_val[i];
      else if (!pull_n[i])
        pin_level[i] = 1'b1;
      else if (pd6[i])
        pin_level[i] = 1'b0;
      else
        pin_level[i] = ~last_r[i];
    end
  end
  always_ff @(posedge sys_clk)
    last_r <= pin_level;
endmodule

// *** sim/gpio_port_tb.sv ***
/*
  Self-checking bench for the six-pin port.
  Assumes the port package and the pad model are compiled first.
*/
`timescale 1ns/100ps
module gpio_port_tb;
  import gpio_port_pkg::*;
  logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0]  pins_in, pins_out, pins_oe, pull_n, ext_en, ext_val;
  logic [3:0]  pull_dn;
  logic [1:0]  op_mode;
  logic        rpad_en, clk_cfg, pwm_cfg, bz_cfg, carrier_d, iclk, pwm_en, bz_en;
  logic        pwm_lvl, bz_lvl, t0_src, t0_low, t1_src, t0_ck, t1_ck, rpad_n;
  logic        chg_irq, ext_irq;
  int          num_errors, checks;

  gpio_port uut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port_pins_in(pins_in),
    .port_pins_out(pins_out), .port_pins_oe(pins_oe), .pad_pullhigh_en_n(pull_n),
    .pad_pulldown_en(pull_dn), .reset_pad_enable(rpad_en), .clk_out_cfg(clk_cfg),
    .pwm_cfg(pwm_cfg), .buzzer_cfg(bz_cfg), .op_mode(op_mode),
    .carrier_out_data(carrier_d), .instr_clk_level(iclk), .pwm_out_enable(pwm_en),
    .buzzer_enable(bz_en), .pwm_level(pwm_lvl), .buzzer_level(bz_lvl),
    .t0_clock_source(t0_src), .t0_low_clock_sel(t0_low), .t1_clock_source(t1_src),
    .t0_ext_clock_in(t0_ck), .t1_ext_clock_in(t1_ck), .reset_pad_input_n(rpad_n),
    .port_change_irq(chg_irq), .ext_int_irq(ext_irq));

  pad_model pads (.sys_clk(sys_clk), .pin_out(pins_out), .pin_oe(pins_oe),
    .pull_n(pull_n), .pull_dn(pull_dn), .ext_en(ext_en), .ext_val(ext_val),
    .pin_level(pins_in));

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ==========================================================================
  // Shared tasks.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Return one edge later, so that the written state has settled.
    @(posedge sys_clk);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd & m, e);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // ==========================================================================
  // Scenarios.
  task automatic t_reset;
    rdchk(OFS_DIRECTION, 32'h0000_003F, {26'h0, RST_DIRECTION});
    chk({26'h0, pins_oe}, 32'h0000_0000);
    chk({26'h0, pull_n}, 32'h0000_003F);
  endtask

  task automatic t_drive;
    apb(1'b1, OFS_PORT_DATA, 32'h0000_0025);
    apb(1'b1, OFS_DIRECTION, 32'h0000_0000);
    chk({20'h0, pins_oe, pins_out}, {20'h0, 6'h3F, 6'h25});
    settle(3);
    rdchk(OFS_PORT_DATA, 32'h0000_003F, 32'h0000_0025);
    apb(1'b1, OFS_DIRECTION, 32'h0000_0001);
    ext_en <= 6'h01;
    apb(1'b1, OFS_PORT_DATA, 32'h0000_0001);
    settle(3);
    rdchk(OFS_PORT_DATA, 32'h0000_0001, 32'h0000_0000);
    apb(1'b1, OFS_READ_SRC, 32'h0000_0001);
    rdchk(OFS_PORT_DATA, 32'h0000_0001, 32'h0000_0001);
    apb(1'b1, OFS_READ_SRC, 32'h0000_0000);
  endtask

  task automatic t_pads;
    apb(1'b1, OFS_PORT_DATA, 32'h0000_003F);
    apb(1'b1, OFS_DIRECTION, 32'h0000_0000);
    chk({26'h0, pins_oe}, 32'h0000_0037);
    apb(1'b1, OFS_OPEN_DRAIN, 32'h0000_0001);
    chk({26'h0, pins_oe}, 32'h0000_0036);
    apb(1'b1, OFS_PULLUP, 32'h0000_003F);
    apb(1'b1, OFS_PULLDOWN, 32'h0000_00F0);
    apb(1'b1, OFS_DIRECTION, 32'h0000_0003);
    chk({26'h0, pull_n}, 32'h0000_003C);
    chk({28'h0, pull_dn}, 32'h0000_0003);
    apb(1'b1, OFS_PULLUP, 32'h0000_0000);
    apb(1'b1, OFS_PULLDOWN, 32'h0000_0000);
    ext_en <= 6'h3F;
    ext_val <= 6'h00;
    apb(1'b1, OFS_DIRECTION, 32'h0000_003F);
  endtask

  task automatic t_wake;
    apb(1'b1, OFS_WAKEUP, 32'h0000_0004);
    settle(3);
    apb(1'b1, OFS_INT_FLAGS, 32'h0000_0000);
    ext_val[2] <= 1'b1;
    settle(3);
    rdchk(OFS_INT_FLAGS, 32'h0000_0002, 32'h0000_0002);
    chk({31'h0, chg_irq}, 32'h0000_0000);
    apb(1'b1, OFS_INT_ENABLES, 32'h0000_0002);
    chk({31'h0, chg_irq}, 32'h0000_0000);
    apb(1'b1, OFS_PWR_CTRL_1, 32'h0000_0080);
    chk({31'h0, chg_irq}, 32'h0000_0001);
    apb(1'b1, OFS_INT_FLAGS, 32'h0000_0000);
    chk({31'h0, chg_irq}, 32'h0000_0000);
    ext_val[1] <= 1'b1;
    settle(3);
    rdchk(OFS_INT_FLAGS, 32'h0000_0002, 32'h0000_0000);
  endtask

  task automatic t_ext;
    apb(1'b1, OFS_WAKEUP, 32'h0000_0001);
    apb(1'b1, OFS_PWR_CTRL, 32'h0000_0060);
    ext_val[0] <= 1'b1;
    settle(3);
    rdchk(OFS_INT_FLAGS, 32'h0000_0006, 32'h0000_0000);
    ext_val[0] <= 1'b0;
    settle(3);
    rdchk(OFS_INT_FLAGS, 32'h0000_0006, 32'h0000_0004);
    apb(1'b1, OFS_INT_ENABLES, 32'h0000_0004);
    chk({31'h0, ext_irq}, 32'h0000_0001);
    apb(1'b1, OFS_PWR_CTRL, 32'h0000_0040);
    apb(1'b1, OFS_INT_FLAGS, 32'h0000_0000);
    ext_val[0] <= 1'b1;
    settle(3);
    rdchk(OFS_INT_FLAGS, 32'h0000_0006, 32'h0000_0004);
    apb(1'b1, OFS_PWR_CTRL, 32'h0000_0000);
    apb(1'b1, OFS_INT_FLAGS, 32'h0000_0000);
    ext_val[0] <= 1'b0;
    settle(3);
    rdchk(OFS_INT_FLAGS, 32'h0000_0006, 32'h0000_0002);
  endtask

  task automatic t_alt;
    carrier_d <= 1'b1;
    apb(1'b1, OFS_CARRIER, 32'h0000_0001);
    chk({30'h0, pins_oe[1], pins_out[1]}, 32'h0000_0003);
    apb(1'b1, OFS_CARRIER, 32'h0000_0000);
    chk({31'h0, pins_oe[1]}, 32'h0000_0000);
    {pwm_cfg, pwm_en, pwm_lvl, bz_cfg, bz_en, bz_lvl} <= 6'b111110;
    settle(1);
    chk({30'h0, pins_oe[2], pins_out[2]}, 32'h0000_0003);
    pwm_en <= 1'b0;
    settle(1);
    chk({30'h0, pins_oe[2], pins_out[2]}, 32'h0000_0002);
    {clk_cfg, iclk, bz_en} <= 3'b110;
    for (int m = 0; m < 4; m++)
    begin
      op_mode <= 2'(m);
      settle(1);
      chk({31'h0, pins_oe[4]}, {31'h0, m == 0 || m == 2});
    end
    {t0_src, t0_low, t1_src} <= 3'b101;
    settle(4);
    chk({30'h0, t0_ck, t1_ck}, 32'h0000_0003);
    t0_low <= 1'b1;
    settle(4);
    chk({31'h0, t0_ck}, 32'h0000_0000);
    rpad_en <= 1'b1;
    settle(4);
    chk({31'h0, rpad_n}, 32'h0000_0000);
    ext_val[3] <= 1'b1;
    settle(4);
    chk({31'h0, rpad_n}, 32'h0000_0001);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk({err, rd[30:0]}, 32'h8000_0000);
  endtask

  // ==========================================================================
  // Verdict, watchdog and main sequence.
  task automatic give_verdict;
    $display("errors=%0d checks=%0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    #200000;
    num_errors++;
    give_verdict();
  end

  initial
  begin
    {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 3'b000, 8'h00, 32'h0000_0000};
    {ext_en, ext_val, op_mode} = {6'h00, 6'h00, 2'b00};
    {rpad_en, clk_cfg, pwm_cfg, bz_cfg, carrier_d, iclk, pwm_en, bz_en} = 8'h00;
    {pwm_lvl, bz_lvl, t0_src, t0_low, t1_src} = 5'h00;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_drive();
    t_pads();
    t_wake();
    t_ext();
    t_alt();
    give_verdict();
  end
endmodule
